// File: design/atc_timer_regs.svh
`ifndef ATC_TIMER_REGS_SVH
`define ATC_TIMER_REGS_SVH

// Register byte addresses on the bus
`define ATC_OFS_CONTROL_A 12'h0b0
`define ATC_OFS_CONTROL_B 12'h0b4
`define ATC_OFS_COUNT 12'h0b8
`define ATC_OFS_COMPARE_A 12'h0bc
`define ATC_OFS_COMPARE_B 12'h0c0
`define ATC_OFS_ASYNC_STATUS 12'h0c4
`define ATC_OFS_GENERAL_CTRL 12'h0c8
`define ATC_OFS_FLAGS 12'h0cc
`define ATC_OFS_IRQ_ENABLE 12'h0d0

// Holding register slots, also busy bit positions in the status register
`define ATC_SLOT_CONTROL_B 0
`define ATC_SLOT_CONTROL_A 1
`define ATC_SLOT_COMPARE_B 2
`define ATC_SLOT_COMPARE_A 3
`define ATC_SLOT_COUNT 4
`define ATC_SLOTS 5

// Field positions
`define ATC_STAT_ASYNC_SELECT 5
`define ATC_GEN_PRESCALER_RESET 1
`define ATC_FLAG_OVERFLOW 0
`define ATC_FLAG_COMPARE_A 1
`define ATC_FLAG_COMPARE_B 2
`define ATC_CTRL_A_CMP_A_MODE 7:6
`define ATC_CTRL_A_CMP_B_MODE 5:4
`define ATC_CTRL_A_WAVE_LOW 1:0
`define ATC_CTRL_B_CLOCK_SELECT 2:0

// Reset values and writable masks
`define ATC_REG_RESET 8'h00
`define ATC_CTRL_A_RW_MASK 8'hf3
`define ATC_CTRL_B_RW_MASK 8'h07
`define ATC_WAVE_CTC 2'h2

// Timing counts
`define ATC_XFER_EDGES 2'h2
`define ATC_FLAG_SYNC_CYCLES 3

`endif

// File: design/atc_timer_pkg.sv
package atc_timer_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} atc_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} atc_apb_rsp_type;

	typedef enum logic [6:0] {
		ATC_ACTIVE = 7'h01,
		ATC_IDLE = 7'h02,
		ATC_NOISE_RED = 7'h04,
		ATC_POWER_SAVE = 7'h08,
		ATC_POWER_DOWN = 7'h10,
		ATC_STANDBY = 7'h20,
		ATC_EXT_STANDBY = 7'h40
	} atc_sleep_type;

	typedef struct packed {
		logic [2:0] osc_sync;
		logic [4:0][7:0] dest;
		logic [4:0][7:0] hold;
		logic [4:0] busy;
		logic [4:0][1:0] edge_cnt;
		logic async_select;
		logic [9:0] presc;
		logic [7:0] count_copy;
		logic [2:0] flag_pend;
		logic [2:0][2:0] flag_pipe;
		logic [2:0] flags;
		logic [2:0] irq_en;
		logic [1:0] pins;
		logic wake;
		logic [31:0] prdata;
		logic pslverr;
		logic lost_sleep;
	} atc_state_type;

endpackage

// File: design/atc_async_timer.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "atc_timer_regs.svh"
// Function
// RULE1: Timer tick is a clock enable; async mode uses oscillator edges instead.
// RULE2: Clock defaults to system clock; async select uses oscillator pin, detaches pins.
// RULE3: Prescaler gives stop, undivided, /8, /32, /64, /128, /256, /1024.
// RULE4: Prescaler reset bit clears prescaler to a known phase.
// RULE5: Writes to count, compares, controls land after two oscillator edges.
// RULE6: Five separate holding registers; writes never disturb other pending transfers.
// RULE7: Status register shows a busy flag per holding register until transferred.
// RULE8: Software waits for busy clear before rewriting the same register.
// RULE9: Compare match suppressed while count or compare write pending.
// RULE10: CPU clock must exceed four times the oscillator frequency.
// RULE11: Switching clock source may corrupt counter, compare and control registers.
// RULE12: Software follows the safe clock-source switch sequence.
// RULE13: Software waits for pending writes before power-save or noise-reduction sleep.
// RULE14: Re-entering sleep within same oscillator cycle fires wake-up again.
// RULE15: Oscillator runs in all sleep states except power-down and standby.
// RULE16: Timer registers are lost after waking from power-down or standby.
// RULE17: Wake-up begins on the timer clock cycle after the interrupt condition.
// RULE18: Counter read through synchronized copy updated on each oscillator rising edge.
// RULE19: Software confirms a busy flag clear before reading counter after wake-up.
// RULE20: Interrupt flags reach CPU three cycles plus one timer cycle later.
// RULE21: Compare output pins change on the timer tick, unsynchronized.
// RULE22: Control A: compare A mode 7:6, compare B mode 5:4, waveform 1:0.
// RULE23: Control A reserved bits always read zero.
// RULE24: Busy flag set by the loading write, held until transfer completes.
module atc_async_timer
	import atc_timer_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire atc_apb_req_type apb_req,
	output atc_apb_rsp_type apb_rsp,
	input wire logic osc_input_pin,
	input wire atc_sleep_type sleep_mode,
	output logic osc_pins_detached,
	output logic osc_run,
	output logic timer_tick_enable,
	output logic [1:0] compare_output_pins,
	output logic [1:0] compare_pins_connected,
	output logic wake_request
);

	atc_state_type st;
	atc_state_type next_st;

	logic osc_rise;
	logic timer_source_clock;
	logic [3:0] sel_index;
	logic bus_setup;
	logic bus_write;
	logic compare_a_hit;
	logic compare_b_hit;
	logic overflow_hit;
	logic [2:0] clear_mask;
	logic [2:0] events;
	logic in_deep_sleep;

	// Shared address decode: slot code 0 to 4, register code 5 to 8, or 4'hf when unmapped
	function automatic logic [3:0] atc_decode(input logic [11:0] addr);
		case (addr)
			`ATC_OFS_CONTROL_B: atc_decode = 4'h0;
			`ATC_OFS_CONTROL_A: atc_decode = 4'h1;
			`ATC_OFS_COMPARE_B: atc_decode = 4'h2;
			`ATC_OFS_COMPARE_A: atc_decode = 4'h3;
			`ATC_OFS_COUNT: atc_decode = 4'h4;
			`ATC_OFS_ASYNC_STATUS: atc_decode = 4'h5;
			`ATC_OFS_GENERAL_CTRL: atc_decode = 4'h6;
			`ATC_OFS_FLAGS: atc_decode = 4'h7;
			`ATC_OFS_IRQ_ENABLE: atc_decode = 4'h8;
			default: atc_decode = 4'hf;
		endcase
	endfunction

	// RULE3 prescaler taps
	function automatic logic atc_tick(input logic [2:0] sel, input logic [9:0] presc,
		input logic src);
		case (sel)
			3'h1: atc_tick = src;
			3'h2: atc_tick = src & (&presc[2:0]);
			3'h3: atc_tick = src & (&presc[4:0]);
			3'h4: atc_tick = src & (&presc[5:0]);
			3'h5: atc_tick = src & (&presc[6:0]);
			3'h6: atc_tick = src & (&presc[7:0]);
			3'h7: atc_tick = src & (&presc[9:0]);
			default: atc_tick = 1'b0;
		endcase
	endfunction

	// Writable bits per slot; reserved ones stay zero
	function automatic logic [7:0] atc_mask(input int slot);
		case (slot)
			`ATC_SLOT_CONTROL_A: atc_mask = `ATC_CTRL_A_RW_MASK;
			`ATC_SLOT_CONTROL_B: atc_mask = `ATC_CTRL_B_RW_MASK;
			default: atc_mask = 8'hff;
		endcase
	endfunction

	// Compare output action on a match, non-PWM behaviour
	function automatic logic atc_pin(input logic [1:0] mode, input logic cur);
		case (mode)
			2'h1: atc_pin = ~cur;
			2'h2: atc_pin = 1'b0;
			2'h3: atc_pin = 1'b1;
			default: atc_pin = cur;
		endcase
	endfunction

	// Only the second and third stages are read; the first is metastability catch
	assign osc_rise = st.osc_sync[1] & ~st.osc_sync[2] & osc_run;

	// RULE15 oscillator runs only with async select set, and stops in the two deepest sleeps
	assign in_deep_sleep = (sleep_mode == ATC_POWER_DOWN) || (sleep_mode == ATC_STANDBY);
	assign osc_run = st.async_select & ~in_deep_sleep;

	// RULE1 source enable: every clock, or each oscillator edge
	assign timer_source_clock = st.async_select ? osc_rise : 1'b1;

	// RULE3 tick from prescaler and clock select
	assign timer_tick_enable = atc_tick(st.dest[`ATC_SLOT_CONTROL_B][`ATC_CTRL_B_CLOCK_SELECT],
		st.presc, timer_source_clock);

	// RULE2 pins leave their port function in async mode
	assign osc_pins_detached = st.async_select;

	assign sel_index = atc_decode(apb_req.paddr);
	assign bus_setup = apb_req.psel & ~apb_req.penable;
	assign bus_write = apb_req.psel & apb_req.penable & apb_req.pwrite & (sel_index != 4'hf);

	// RULE9 no match while the compared values are in flight
	assign compare_a_hit = timer_tick_enable & ~st.busy[`ATC_SLOT_COUNT]
		& ~st.busy[`ATC_SLOT_COMPARE_A]
		& (st.dest[`ATC_SLOT_COUNT] == st.dest[`ATC_SLOT_COMPARE_A]);
	assign compare_b_hit = timer_tick_enable & ~st.busy[`ATC_SLOT_COUNT]
		& ~st.busy[`ATC_SLOT_COMPARE_B]
		& (st.dest[`ATC_SLOT_COUNT] == st.dest[`ATC_SLOT_COMPARE_B]);
	assign overflow_hit = timer_tick_enable & (st.dest[`ATC_SLOT_COUNT] == 8'hff);

	always_comb begin
		events = 3'h0;
		events[`ATC_FLAG_OVERFLOW] = overflow_hit;
		events[`ATC_FLAG_COMPARE_A] = compare_a_hit;
		events[`ATC_FLAG_COMPARE_B] = compare_b_hit;
		clear_mask = 3'h0;
		if (bus_write && sel_index == 4'h7) begin
			clear_mask = apb_req.pwdata[2:0];
		end
	end

	always_comb begin
		next_st = st;
		next_st.osc_sync = {st.osc_sync[1:0], osc_input_pin};

		// Prescaler advances on each source enable
		if (timer_source_clock) begin
			next_st.presc = st.presc + 10'h001;
		end

		// RULE18 counter copy follows the core on each source enable: each oscillator edge, or every clock
		if (timer_source_clock) begin
			next_st.count_copy = st.dest[`ATC_SLOT_COUNT];
		end

		// Counter advance, CTC clear on compare A
		if (timer_tick_enable) begin
			if (st.dest[`ATC_SLOT_CONTROL_A][`ATC_CTRL_A_WAVE_LOW] == `ATC_WAVE_CTC
				&& compare_a_hit) begin
				next_st.dest[`ATC_SLOT_COUNT] = 8'h00;
			end else begin
				next_st.dest[`ATC_SLOT_COUNT] = st.dest[`ATC_SLOT_COUNT] + 8'h01;
			end
		end

		// RULE21 pins move with the tick itself
		if (compare_a_hit) begin
			next_st.pins[0] = atc_pin(st.dest[`ATC_SLOT_CONTROL_A][`ATC_CTRL_A_CMP_A_MODE],
				st.pins[0]);
		end
		if (compare_b_hit) begin
			next_st.pins[1] = atc_pin(st.dest[`ATC_SLOT_CONTROL_A][`ATC_CTRL_A_CMP_B_MODE],
				st.pins[1]);
		end

		// RULE5 transfer after two source edges, per slot
		for (int i = 0; i < `ATC_SLOTS; i++) begin
			if (st.busy[i] && timer_source_clock) begin
				if (st.edge_cnt[i] == `ATC_XFER_EDGES - 2'h1) begin
					// RULE7 busy drops as the value lands
					next_st.dest[i] = st.hold[i];
					next_st.busy[i] = 1'b0;
					next_st.edge_cnt[i] = 2'h0;
				end else begin
					next_st.edge_cnt[i] = st.edge_cnt[i] + 2'h1;
				end
			end
		end

		// RULE20 one timer cycle in the pending stage, then three CPU cycles
		next_st.flag_pipe[0] = timer_source_clock ? st.flag_pend : 3'h0;
		next_st.flag_pipe[1] = st.flag_pipe[0];
		next_st.flag_pipe[2] = st.flag_pipe[1];
		if (timer_source_clock) begin
			next_st.flag_pend = events;
		end else begin
			next_st.flag_pend = st.flag_pend | events;
		end
		// Set wins over a clear in the same cycle
		next_st.flags = (st.flags & ~clear_mask) | st.flag_pipe[`ATC_FLAG_SYNC_CYCLES - 1];

		// RULE17 wake follows the flag, so the counter has moved on
		// RULE14 a level request fires again on any sleep re-entry
		next_st.wake = |(st.flags & st.irq_en);

		// RULE16 deep sleep loses the five slot registers and the counter copy
		next_st.lost_sleep = in_deep_sleep;
		if (st.lost_sleep && !in_deep_sleep) begin
			for (int i = 0; i < `ATC_SLOTS; i++) begin
				next_st.dest[i] = `ATC_REG_RESET;
				next_st.hold[i] = `ATC_REG_RESET;
			end
			next_st.count_copy = `ATC_REG_RESET;
		end

		// Register writes at the access phase
		if (bus_write) begin
			if (sel_index < 4'h5) begin
				// RULE6 each write owns only its slot
				// RULE24 loading write raises busy
				next_st.hold[sel_index[2:0]] = apb_req.pwdata[7:0] & atc_mask(int'(sel_index));
				next_st.busy[sel_index[2:0]] = 1'b1;
				next_st.edge_cnt[sel_index[2:0]] = 2'h0;
			end else if (sel_index == 4'h5) begin
				// RULE11 no protection on a source switch; software rewrites
				next_st.async_select = apb_req.pwdata[`ATC_STAT_ASYNC_SELECT];
			end else if (sel_index == 4'h6) begin
				// RULE4 prescaler restarts from zero
				if (apb_req.pwdata[`ATC_GEN_PRESCALER_RESET]) begin
					next_st.presc = 10'h000;
				end
			end else if (sel_index == 4'h8) begin
				next_st.irq_en = apb_req.pwdata[2:0];
			end
		end

		// Read data captured in the setup cycle
		next_st.pslverr = 1'b0;
		if (bus_setup) begin
			next_st.prdata = 32'h0000_0000;
			next_st.pslverr = (sel_index == 4'hf);
			case (sel_index)
				4'h0: next_st.prdata[7:0] = st.dest[`ATC_SLOT_CONTROL_B];
				// RULE22 control A layout
				// RULE23 reserved bits read zero
				4'h1: next_st.prdata[7:0] = st.dest[`ATC_SLOT_CONTROL_A] & `ATC_CTRL_A_RW_MASK;
				4'h2: next_st.prdata[7:0] = st.dest[`ATC_SLOT_COMPARE_B];
				4'h3: next_st.prdata[7:0] = st.dest[`ATC_SLOT_COMPARE_A];
				// RULE18 reads never touch the core counter
				4'h4: next_st.prdata[7:0] = st.count_copy;
				4'h5: begin
					next_st.prdata[4:0] = st.busy;
					next_st.prdata[`ATC_STAT_ASYNC_SELECT] = st.async_select;
				end
				4'h7: next_st.prdata[2:0] = st.flags;
				4'h8: next_st.prdata[2:0] = st.irq_en;
				default: next_st.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Zero wait state: access phase always completes
	assign apb_rsp.prdata = st.prdata;
	assign apb_rsp.pready = apb_req.psel & apb_req.penable;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & st.pslverr;

	assign compare_output_pins = st.pins;
	assign compare_pins_connected[0] =
		|st.dest[`ATC_SLOT_CONTROL_A][`ATC_CTRL_A_CMP_A_MODE];
	assign compare_pins_connected[1] =
		|st.dest[`ATC_SLOT_CONTROL_A][`ATC_CTRL_A_CMP_B_MODE];
	assign wake_request = st.wake;

endmodule // atc_async_timer

// File: bench/atc_async_timer_sva.sv
`timescale 1ns/1ps
`include "atc_timer_regs.svh"
module atc_async_timer_sva
	import atc_timer_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire atc_apb_req_type apb_req,
	input wire atc_apb_rsp_type apb_rsp,
	input wire logic osc_input_pin,
	input wire atc_sleep_type sleep_mode,
	input wire logic osc_pins_detached,
	input wire logic osc_run,
	input wire logic timer_tick_enable,
	input wire logic [1:0] compare_output_pins,
	input wire logic [1:0] compare_pins_connected,
	input wire logic wake_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire acc = apb_req.psel && apb_req.penable;
	wire deep = (sleep_mode == ATC_POWER_DOWN) || (sleep_mode == ATC_STANDBY);
	a_default_sync_clock: assert property (
		$rose(arst_n) |-> !osc_pins_detached && compare_pins_connected == 2'h0)
		else $error("clock source not system clock after reset");
	a_select_follows_write: assert property (
		acc && apb_req.pwrite && apb_req.paddr == `ATC_OFS_ASYNC_STATUS
		|=> osc_pins_detached == $past(apb_req.pwdata[`ATC_STAT_ASYNC_SELECT]))
		else $error("pin detach does not follow async select");
	a_osc_stops_deep: assert property (deep |-> !osc_run)
		else $error("oscillator runs in deep sleep");
	a_osc_runs_light: assert property (!deep |-> osc_run == osc_pins_detached)
		else $error("oscillator run state wrong");
	a_reserved_read_zero: assert property (
		acc && !apb_req.pwrite && apb_req.paddr == `ATC_OFS_CONTROL_A
		|-> apb_rsp.prdata[3:2] == 2'h0 && apb_rsp.prdata[31:8] == 24'h0)
		else $error("reserved control bits not zero");
	a_pins_on_tick: assert property (
		$changed(compare_output_pins) |-> $past(timer_tick_enable))
		else $error("compare pin moved without tick");
	a_tick_stopped_reset: assert property ($rose(arst_n) |-> !timer_tick_enable [*4])
		else $error("tick while clock stopped");
	a_lost_after_deep: assert property (
		$past(sleep_mode) == ATC_POWER_DOWN && sleep_mode == ATC_ACTIVE
		|-> ##[1:3] compare_pins_connected == 2'h0)
		else $error("control kept after power-down");
	a_zero_wait_ready: assert property (apb_rsp.pready == acc)
		else $error("ready not in access phase");
endmodule // atc_async_timer_sva

bind atc_async_timer atc_async_timer_sva atc_async_timer_sva_inst (.clk(clk), .arst_n(arst_n),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .osc_input_pin(osc_input_pin),
	.sleep_mode(sleep_mode), .osc_pins_detached(osc_pins_detached), .osc_run(osc_run),
	.timer_tick_enable(timer_tick_enable), .compare_output_pins(compare_output_pins),
	.compare_pins_connected(compare_pins_connected), .wake_request(wake_request));

// File: bench/atc_osc_model.sv
`timescale 1ns/1ps
// Crystal stand-in, phase unrelated to the bus clock
module atc_osc_model #(
	parameter real HALF_NS = 131.0
) (
	input wire logic osc_en,
	output logic osc_pin
);
	initial osc_pin = 1'b0;
	always begin
		#(HALF_NS);
		osc_pin = osc_en ? ~osc_pin : 1'b0;
	end
endmodule // atc_osc_model

// File: bench/atc_async_timer_tb_top.sv
`timescale 1ns/1ps
`include "atc_timer_regs.svh"
module atc_async_timer_tb_top;
	import atc_timer_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	atc_apb_req_type req = '0;
	atc_apb_rsp_type rsp;
	atc_sleep_type sleep_mode = ATC_ACTIVE;
	logic osc_pin;
	logic osc_run;
	logic tick;
	logic wake;
	logic [32:0] exp_q[$];
	int num_errors = 0;
	int checked = 0;
	int seed = 32'h7c46;
	int ticks;
	int wait_cnt;
	int div[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
	logic [7:0] va;
	logic [7:0] vb;
	always #12.5 clk = ~clk;
	atc_async_timer atc_async_timer_inst (.clk(clk), .arst_n(arst_n), .apb_req(req),
		.apb_rsp(rsp), .osc_input_pin(osc_pin), .sleep_mode(sleep_mode),
		.osc_pins_detached(), .osc_run(osc_run), .timer_tick_enable(tick),
		.compare_output_pins(), .compare_pins_connected(), .wake_request(wake));
	atc_osc_model atc_osc_model_inst (.osc_en(osc_run), .osc_pin(osc_pin));
	task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task results;
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20)
			num_errors++;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// Oldest note matched against each completed read
	always @(posedge clk)
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
			check("read", {rsp.pslverr, rsp.prdata}, exp_q.pop_front());
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		results();
	end
	task count_ticks(input int len);
		ticks = 0;
		repeat (len) begin
			@(posedge clk);
			if (tick === 1'b1)
				ticks++;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(`ATC_OFS_CONTROL_A, 33'h0);
		rd(`ATC_OFS_ASYNC_STATUS, 33'h0);
		apb(1'b1, `ATC_OFS_CONTROL_A, 32'hff);
		repeat (6) @(posedge clk);
		rd(`ATC_OFS_CONTROL_A, 33'hf3);
		// Whole multiples of the period give exact counts whatever the phase
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, `ATC_OFS_CONTROL_B, 32'(c));
			repeat (8) @(posedge clk);
			count_ticks(2048);
			check("ticks", 33'(ticks), c == 0 ? 33'h0 : 33'(2048 / div[c]));
		end
		repeat (100 + ($random(seed) & 8'hff)) @(posedge clk);
		apb(1'b1, `ATC_OFS_GENERAL_CTRL, 32'h2);
		count_ticks(1000);
		check("reset phase", 33'(ticks), 33'h0);
		apb(1'b1, `ATC_OFS_CONTROL_A, 32'h50);
		repeat (6) @(posedge clk);
		sleep_mode <= ATC_POWER_DOWN;
		repeat (4) @(posedge clk);
		sleep_mode <= ATC_ACTIVE;
		repeat (4) @(posedge clk);
		rd(`ATC_OFS_CONTROL_A, 33'h0);
		rd(`ATC_OFS_CONTROL_B, 33'h0);
		rd(12'h0fc, 33'h100000000);
		// interrupts off before the source switch
		apb(1'b1, `ATC_OFS_IRQ_ENABLE, 32'h0);
		apb(1'b1, `ATC_OFS_ASYNC_STATUS, 32'h20);
		repeat (60) @(posedge clk);
		va = 8'($random(seed));
		vb = 8'($random(seed));
		apb(1'b1, `ATC_OFS_COMPARE_A, {24'h0, va});
		rd(`ATC_OFS_ASYNC_STATUS, 33'h28);
		apb(1'b1, `ATC_OFS_COMPARE_B, {24'h0, vb});
		repeat (60) @(posedge clk);
		rd(`ATC_OFS_ASYNC_STATUS, 33'h20);
		rd(`ATC_OFS_COMPARE_A, {25'h0, va});
		rd(`ATC_OFS_COMPARE_B, {25'h0, vb});
		// rewrite the counter and both compare registers after the switch
		apb(1'b1, `ATC_OFS_COUNT, 32'h0);
		apb(1'b1, `ATC_OFS_COMPARE_A, 32'h20);
		apb(1'b1, `ATC_OFS_COMPARE_B, 32'h40);
		// no rewrite until every busy flag is clear
		repeat (60) @(posedge clk);
		rd(`ATC_OFS_ASYNC_STATUS, 33'h20);
		apb(1'b1, `ATC_OFS_FLAGS, 32'h7);
		rd(`ATC_OFS_FLAGS, 33'h0);
		apb(1'b1, `ATC_OFS_IRQ_ENABLE, 32'h2);
		apb(1'b1, `ATC_OFS_CONTROL_B, 32'h1);
		wait_cnt = 0;
		while (wake !== 1'b1 && wait_cnt < 2000) begin
			@(posedge clk);
			wait_cnt++;
		end
		check("wake", 33'(wake), 33'h1);
		rd(`ATC_OFS_FLAGS, 33'h2);
		apb(1'b1, `ATC_OFS_CONTROL_B, 32'h0);
		repeat (60) @(posedge clk);
		va = 8'($random(seed));
		apb(1'b1, `ATC_OFS_COUNT, {24'h0, va});
		repeat (60) @(posedge clk);
		sleep_mode <= ATC_POWER_SAVE;
		repeat (4) @(posedge clk);
		check("osc run", 33'(osc_run), 33'h1);
		sleep_mode <= ATC_ACTIVE;
		// busy clear before the counter read
		rd(`ATC_OFS_ASYNC_STATUS, 33'h20);
		rd(`ATC_OFS_COUNT, {25'h0, va});
		repeat (4) @(posedge clk);
		results();
	end
endmodule // atc_async_timer_tb_top
